// ==== rtl/ext_int_pkg.sv ====
// constants for the external interrupt front end
package ext_int_pkg;
	localparam logic [11:0] clock_gate_offset   = 12'hf77;
	localparam logic [11:0] one_control_offset  = 12'hfd8;
	localparam logic [11:0] irq_status_offset   = 12'hfe0;
	localparam logic [11:0] irq_mask_offset     = 12'hfe1;
	localparam logic [11:0] op_mode_offset      = 12'hfe2;
	localparam logic [7:0]  clock_gate_reset    = 8'h00;
	localparam logic [7:0]  one_control_reset   = 8'h00;
	localparam logic [7:0]  irq_mask_reset      = 8'h00;
	localparam int          channel_count       = 6;
	localparam int          gate_chan1_bit      = 1;
	localparam int          level_flag_bit      = 4;
	localparam int          edge_select_lsb     = 2;
	localparam int          interval_select_lsb = 0;
	localparam int          filter_samples      = 2;
	localparam int          clock_mhz           = 50;
	localparam int          slow_prescale       = 4;
	typedef enum logic [1:0] {edge_rising, edge_falling, edge_both, edge_reserved} edge_e;
	typedef enum logic [1:0] {div_1, div_4, div_8, div_16} interval_e;
endpackage

// ==== rtl/ext_interrupt_filter_control.sv ====
// one external interrupt channel front end with six channel clock gates
//
// How it works
// RQ1: enable bit 0 gates channel clock off; all six enables reset to zero.
// RQ2: control register writes are dropped while channel one clock is disabled.
// RQ3: software clears interrupt enable before toggling a channel clock enable.
// RQ4: software clears interrupt enable before changing operating mode.
// RQ5: fast to slow switch: wait twelve slow periods, then clear latch.
// RQ6: slow to fast: wait two gear plus three sample periods, clear latch.
// RQ7: clock gate bits seven and six always read zero.
// RQ8: level flag holds filtered level captured at each request.
// RQ9: edge select 00 rising, 01 falling, 10 both, 11 reserved none.
// RQ10: fast modes sample gear, /4, /8, /16; slow modes slow clock /4.
// RQ11: software clears interrupt enable before rewriting the control register.
// RQ12: control bits seven to five read zero; register resets to zero.
// RQ13: raised request latch holds until accepted or cleared.
// RQ14: filter passes a level only after consecutive equal samples.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module ext_interrupt_filter_control
	import ext_int_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [11:0] address,
	input  wire logic [7:0]  write_data,
	input  wire logic        write_strobe,
	input  wire logic        read_strobe,
	output logic      [7:0]  read_data,
	input  wire logic        ext_pin,
	input  wire logic        low_freq_tick,
	input  wire logic        request_accept,
	output logic      [5:0]  channel_clock_enable,
	output logic             request_latch,
	output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// registers

	logic [5:0] gate;
	logic [1:0] edge_select;
	logic [1:0] sample_interval_select;
	logic       filtered_level_flag;
	logic       slow_mode;
	logic       irq_status;
	logic       irq_mask;
	logic       chan_on;
	logic       wr_gate;
	logic       wr_ctrl;
	logic       rd_status;
	logic       raise;
	logic       filtered;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	assign wr_gate   = write_strobe && hit(address, clock_gate_offset);
	assign wr_ctrl   = write_strobe && hit(address, one_control_offset);
	assign rd_status = read_strobe && hit(address, irq_status_offset);
	assign chan_on   = gate[gate_chan1_bit];
	assign channel_clock_enable = gate; // RQ1

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			gate <= clock_gate_reset[5:0]; // RQ1
		end else if (wr_gate) begin
			gate <= write_data[5:0];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			edge_select            <= one_control_reset[3:2]; // RQ12
			sample_interval_select <= one_control_reset[1:0];
		end else if (!chan_on) begin
			edge_select            <= one_control_reset[3:2]; // RQ2
			sample_interval_select <= one_control_reset[1:0];
		end else if (wr_ctrl) begin
			edge_select            <= write_data[edge_select_lsb +: 2];
			sample_interval_select <= write_data[interval_select_lsb +: 2];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			slow_mode <= 1'b0;
			irq_mask  <= irq_mask_reset[0];
		end else if (write_strobe) begin
			if (hit(address, op_mode_offset)) begin
				slow_mode <= write_data[0];
			end
			if (hit(address, irq_mask_offset)) begin
				irq_mask <= write_data[0];
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			read_data <= 8'h00;
		end else if (read_strobe) begin
			case (address)
				clock_gate_offset:  read_data <= {2'b00, gate}; // RQ7
				one_control_offset: read_data <= {3'b000, filtered_level_flag,
					edge_select, sample_interval_select}; // RQ12
				irq_status_offset:  read_data <= {7'h00, irq_status};
				irq_mask_offset:    read_data <= {7'h00, irq_mask};
				op_mode_offset:     read_data <= {7'h00, slow_mode};
				default:            read_data <= 8'h00;
			endcase
		end else begin
			read_data <= 8'h00;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// sampling clock and noise filter

	logic       pin_meta;
	logic       pin_sync;
	logic       slow_sync_a;
	logic       slow_sync_b;
	logic       slow_prev;
	logic [3:0] div_count;
	logic [1:0] slow_count;
	logic       sample_tick;
	logic [1:0] stable_count;
	logic       fast_tick;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pin_meta    <= 1'b0;
			pin_sync    <= 1'b0;
			slow_sync_a <= 1'b0;
			slow_sync_b <= 1'b0;
			slow_prev   <= 1'b0;
		end else begin
			pin_meta    <= ext_pin;
			pin_sync    <= pin_meta;
			slow_sync_a <= low_freq_tick;
			slow_sync_b <= slow_sync_a;
			slow_prev   <= slow_sync_b;
		end
	end

	always_comb begin
		case (interval_e'(sample_interval_select))
			div_1:   fast_tick = 1'b1;
			div_4:   fast_tick = div_count[1:0] == 2'h3;
			div_8:   fast_tick = div_count[2:0] == 3'h7;
			div_16:  fast_tick = div_count == 4'hf;
			default: fast_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			div_count  <= 4'h0;
			slow_count <= 2'h0;
		end else if (chan_on) begin
			div_count <= div_count + 4'h1;
			if (slow_sync_b && !slow_prev) begin
				slow_count <= slow_count + 2'h1;
			end
		end
	end

	// slow modes ignore the interval code and use the slow clock over four
	assign sample_tick = chan_on && (slow_mode ? (slow_sync_b && !slow_prev &&
		slow_count == 2'(slow_prescale - 1)) : fast_tick); // RQ10

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			filtered     <= 1'b0;
			stable_count <= 2'h0;
		end else if (sample_tick) begin
			if (pin_sync == filtered) begin
				stable_count <= 2'h0;
			end else if (stable_count == 2'(filter_samples - 1)) begin
				filtered     <= pin_sync; // RQ14
				stable_count <= 2'h0;
			end else begin
				stable_count <= stable_count + 2'h1;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// edge detection, level flag, request latch, interrupt

	logic filtered_prev;
	logic rose;
	logic fell;
	logic edge_hit;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			filtered_prev <= 1'b0;
		end else begin
			filtered_prev <= filtered;
		end
	end

	assign rose = filtered && !filtered_prev;
	assign fell = !filtered && filtered_prev;

	always_comb begin
		case (edge_e'(edge_select))
			edge_rising:  edge_hit = rose; // RQ9
			edge_falling: edge_hit = fell;
			edge_both:    edge_hit = rose || fell;
			default:      edge_hit = 1'b0;
		endcase
	end

	// a gated channel raises nothing
	assign raise = edge_hit && chan_on; // RQ1

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			filtered_level_flag <= 1'b0;
		end else if (!chan_on) begin
			filtered_level_flag <= 1'b0;
		end else if (raise) begin
			filtered_level_flag <= filtered; // RQ8
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			request_latch <= 1'b0;
		end else if (raise) begin
			request_latch <= 1'b1; // RQ13
		end else if (request_accept) begin
			request_latch <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq_status <= 1'b0;
		end else if (raise) begin
			irq_status <= 1'b1;
		end else if (rd_status) begin
			irq_status <= 1'b0;
		end
	end

	assign irq = irq_status && irq_mask;

////////////////////////////////////////////////////////////////////////////////
// checks

	sequence s_edge_raise;
		chan_on && edge_select == 2'b10 && (rose || fell);
	endsequence

	sequence s_rise_raise;
		chan_on && edge_select == 2'h0 && rose;
	endsequence

	sequence s_fall_raise;
		chan_on && edge_select == 2'h1 && fell;
	endsequence

	a_gate_reads_zero: assert property (@(posedge clock) disable iff (reset) // RQ7
		read_strobe && hit(address, clock_gate_offset) |=> read_data[7:6] == 2'b00)
		else $error("clock gate upper bits not zero");

	a_ctrl_reads_zero: assert property (@(posedge clock) disable iff (reset) // RQ12
		read_strobe && hit(address, one_control_offset) |=> read_data[7:5] == 3'b000)
		else $error("control upper bits not zero");

	a_gated_write_lost: assert property (@(posedge clock) disable iff (reset) // RQ2
		!chan_on |=> edge_select == 2'b00 && sample_interval_select == 2'b00)
		else $error("control kept while channel clock off");

	a_gate_follows: assert property (@(posedge clock) disable iff (reset) // RQ1
		wr_gate |=> channel_clock_enable == $past(write_data[5:0]))
		else $error("clock gate did not take write");

	a_both_edges: assert property (@(posedge clock) disable iff (reset) // RQ9
		s_edge_raise |=> request_latch && filtered_level_flag == $past(filtered))
		else $error("both edge request missed");

	a_reserved_none: assert property (@(posedge clock) disable iff (reset) // RQ9
		edge_select == 2'b11 |-> !raise)
		else $error("reserved edge code raised request");

	a_latch_holds: assert property (@(posedge clock) disable iff (reset) // RQ13
		request_latch && !request_accept |=> request_latch)
		else $error("request latch dropped early");

	a_filter_stable: assert property (@(posedge clock) disable iff (reset) // RQ14
		$changed(filtered) |-> $past(pin_sync) == filtered)
		else $error("filter passed unsettled level");

	a_fast_div16: assert property (@(posedge clock) disable iff (reset) // RQ10
		chan_on && !slow_mode && sample_interval_select == 2'b11 && sample_tick
		|=> !(sample_tick && !slow_mode && sample_interval_select == 2'h3) [*8])
		else $error("divide by sixteen tick too often");

	a_fast_div8: assert property (@(posedge clock) disable iff (reset) // RQ10
		chan_on && !slow_mode && sample_interval_select == 2'h2 && sample_tick
		|=> !(sample_tick && !slow_mode && sample_interval_select == 2'h2) [*7])
		else $error("divide by eight tick too often");

	a_fast_div4: assert property (@(posedge clock) disable iff (reset) // RQ10
		chan_on && !slow_mode && sample_interval_select == 2'h1 && sample_tick
		|=> !(sample_tick && !slow_mode && sample_interval_select == 2'h1) [*3])
		else $error("divide by four tick too often");

	a_slow_rate: assert property (@(posedge clock) disable iff (reset) // RQ10
		chan_on && slow_mode && sample_tick
		|=> !(sample_tick && slow_mode) [*7])
		else $error("slow sample tick too often");

	a_rise_raises: assert property (@(posedge clock) disable iff (reset) // RQ9
		s_rise_raise |=> request_latch && filtered_level_flag)
		else $error("rising edge request missed");

	a_fall_raises: assert property (@(posedge clock) disable iff (reset) // RQ9
		s_fall_raise |=> request_latch && !filtered_level_flag)
		else $error("falling edge request missed");

	a_flag_holds: assert property (@(posedge clock) disable iff (reset) // RQ8
		chan_on && !raise |=> $stable(filtered_level_flag))
		else $error("level flag changed without request");

	a_gated_quiet: assert property (@(posedge clock) disable iff (reset) // RQ1
		!chan_on && !request_latch |=> !request_latch)
		else $error("gated channel raised request");

	a_gated_frozen: assert property (@(posedge clock) disable iff (reset) // RQ1
		!chan_on |=> $stable(div_count) && $stable(slow_count))
		else $error("gated channel dividers still running");

	a_ctrl_write_takes: assert property (@(posedge clock) disable iff (reset) // RQ2
		chan_on && wr_ctrl |=> edge_select == $past(write_data[3:2]) &&
			sample_interval_select == $past(write_data[1:0]))
		else $error("control write lost while channel clocked");

	a_latch_accept: assert property (@(posedge clock) disable iff (reset) // RQ13
		request_accept && !raise |=> !request_latch)
		else $error("request latch not cleared on accept");

	a_status_set_wins: assert property (@(posedge clock) disable iff (reset)
		raise |=> irq_status)
		else $error("status bit not set by request");

	a_status_read_clears: assert property (@(posedge clock) disable iff (reset)
		rd_status && !raise |=> !irq_status)
		else $error("status bit not cleared by read");

	a_read_idle: assert property (@(posedge clock) disable iff (reset)
		!read_strobe |=> read_data == 8'h00)
		else $error("read data not zero when idle");

endmodule

// ==== tb/pin_source.sv ====
// model of the external pin and the free-running low-frequency oscillator
`timescale 1ns/100ps
module pin_source (
	input  wire logic clock,
	output logic      ext_pin,
	output logic      low_freq_tick
);
	initial begin
		ext_pin = 1'b0;
		low_freq_tick = 1'b0;
	end
	always begin
		#163 low_freq_tick = ~low_freq_tick;
	end
	task automatic drive(input logic level, input int hold);
		@(posedge clock);
		ext_pin <= level;
		repeat (hold - 1) @(posedge clock);
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the external interrupt front end
`timescale 1ns/100ps
module testbench;
	import ext_int_pkg::*;
	logic        clock;
	logic        reset;
	logic [11:0] address;
	logic [7:0]  write_data;
	logic        write_strobe;
	logic        read_strobe;
	logic [7:0]  read_data;
	logic        ext_pin;
	logic        low_freq_tick;
	logic        request_accept;
	logic [5:0]  channel_clock_enable;
	logic        request_latch;
	logic        irq;
	logic        lvl;
	int          bad_count;
	int          total_checks;
////////////////////////////////
	ext_interrupt_filter_control u_ext_interrupt_filter_control (.clock(clock), .reset(reset),
		.address(address), .write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data), .ext_pin(ext_pin),
		.low_freq_tick(low_freq_tick), .request_accept(request_accept),
		.channel_clock_enable(channel_clock_enable), .request_latch(request_latch), .irq(irq));
	pin_source u_pin_source (.clock(clock), .ext_pin(ext_pin), .low_freq_tick(low_freq_tick));
	always #10 clock = ~clock;
////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		@(negedge clock);
		check(read_data, exp);
	endtask
	task automatic clear_latch;
		@(posedge clock);
		request_accept <= 1'b1;
		address <= irq_status_offset;
		read_strobe <= 1'b1;
		@(posedge clock);
		request_accept <= 1'b0;
		read_strobe <= 1'b0;
	endtask
	// one pin change, then irq, captured level, latch and status are judged
	task automatic edge_step(input logic level, input logic hit, input logic [3:0] ctl,
		input int hold, input logic msk);
		u_pin_source.drive(level, hold);
		check(irq, hit & msk);
		if (hit)
			lvl = level;
		rd(one_control_offset, {3'h0, lvl, ctl});
		check(request_latch, hit);
		rd(irq_status_offset, {7'h0, hit});
		check(request_latch, hit);
		check(irq, 1'b0);
		clear_latch();
		@(negedge clock);
		check(request_latch, 1'b0);
	endtask
////////////////////////////////
	task automatic t_reset;
		rd(clock_gate_offset, clock_gate_reset);
		rd(one_control_offset, one_control_reset);
		rd(irq_mask_offset, irq_mask_reset);
		rd(irq_status_offset, 8'h00);
		rd(op_mode_offset, 8'h00);
		rd(12'h000, 8'h00);
		check(channel_clock_enable, 6'h00);
		check(irq, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_gate;
		wr(one_control_offset, 8'h0d);
		rd(one_control_offset, 8'h00);
		wr(clock_gate_offset, 8'hff);
		@(negedge clock);
		check(channel_clock_enable, 6'h3f);
		rd(clock_gate_offset, 8'h3f);
		wr(one_control_offset, 8'hff);
		rd(one_control_offset, 8'h0f);
		$display("test gate done");
	endtask
	task automatic t_edges;
		logic [3:0] ctl;
		for (int c = 0; c < 4; c++) begin
			ctl = {c[1:0], c[1:0]};
			wr(irq_mask_offset, 8'h00);
			wr(one_control_offset, {4'h0, ctl});
			wr(irq_mask_offset, {7'h0, c[0]});
			edge_step(1'b1, c == 0 || c == 2, ctl, 40, c[0]);
			edge_step(1'b0, c == 1 || c == 2, ctl, 40, c[0]);
		end
		$display("test edges done");
	endtask
	task automatic t_filter;
		wr(irq_mask_offset, 8'h00);
		wr(one_control_offset, 8'h00);
		u_pin_source.drive(1'b1, 1);
		edge_step(1'b0, 1'b0, 4'h0, 20, 1'b0);
		wr(one_control_offset, 8'h03);
		u_pin_source.drive(1'b1, 8);
		edge_step(1'b0, 1'b0, 4'h3, 40, 1'b0);
		edge_step(1'b1, 1'b1, 4'h3, 60, 1'b0);
		$display("test filter done");
	endtask
	task automatic t_slow;
		wr(op_mode_offset, 8'h01);
		repeat (220) @(posedge clock);
		clear_latch();
		wr(one_control_offset, 8'h0b);
		u_pin_source.drive(1'b0, 20);
		edge_step(1'b1, 1'b0, 4'hb, 20, 1'b0);
		edge_step(1'b0, 1'b1, 4'hb, 400, 1'b0);
		edge_step(1'b1, 1'b1, 4'hb, 400, 1'b0);
		wr(op_mode_offset, 8'h00);
		repeat (60) @(posedge clock);
		clear_latch();
		edge_step(1'b0, 1'b1, 4'hb, 40, 1'b0);
		wr(clock_gate_offset, 8'h00);
		@(negedge clock);
		check(channel_clock_enable, 6'h00);
		rd(one_control_offset, 8'h00);
		$display("test slow and gate off done");
	endtask
	task automatic t_mid_reset;
		wr(clock_gate_offset, 8'h3f);
		wr(irq_mask_offset, 8'h01);
		@(posedge clock);
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		$display("test mid reset done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
////////////////////////////////
	initial begin
		repeat (10000) @(posedge clock);
		bad_count++;
		wrap_up();
	end
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		address = 12'h000;
		write_data = 8'h00;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		request_accept = 1'b0;
		lvl = 1'b0;
		bad_count = 0;
		total_checks = 0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_gate();
		t_edges();
		t_filter();
		t_slow();
		t_mid_reset();
		wrap_up();
	end
endmodule
